// *** hw/mscc_map.svh ***
`ifndef MSCC_MAP_SVH
`define MSCC_MAP_SVH
// operating mode codes
`define MSCC_MODE_ASYNC_FB    3'h0
`define MSCC_MODE_V32_TERMINAL_SYNC_INPUT   3'h4
`define MSCC_MODE_V32_INT     3'h5
`define MSCC_MODE_V32_LOOP    3'h6
`define MSCC_MODE_ASYNC_TERMINAL_SYNC_INPUT 3'h7
// timing: master clock assumed by the divider constants
`define MSCC_MCLK_HZ          13824000
`define MSCC_CONV_DIV         1440
`define MSCC_BIT_DIV          3
`define MSCC_SYM_DIV          4
`define MSCC_PHASE_W          8
`define MSCC_RESET_CYCLES     4'h8
`endif

// *** hw/mscc_pkg.sv ***
package mscc_pkg;
    typedef enum logic [2:0] {
        MSCC_ASYNC_FB    = 3'b000,
        MSCC_V32_TERMINAL_SYNC_INPUT   = 3'b100,
        MSCC_V32_INT     = 3'b101,
        MSCC_V32_LOOP    = 3'b110,
        MSCC_ASYNC_TERMINAL_SYNC_INPUT = 3'b111
    } mscc_mode_type;

    typedef enum logic [1:0] {
        MSCC_LK_IDLE  = 2'b00,
        MSCC_LK_RXTX  = 2'b01,
        MSCC_LK_TRACK = 2'b10
    } mscc_lock_type;

    typedef struct packed {
        logic convert;
        logic bitClk;
        logic symbolClk;
    } mscc_strobes_type;
endpackage

// *** hw/mscc_strobe_gen.sv ***
`timescale 1ns/1ps
`include "mscc_map.svh"
module mscc_strobe_gen #(
    parameter int CONV_DIV = `MSCC_CONV_DIV,
    parameter int BIT_DIV  = `MSCC_BIT_DIV,
    parameter int SYM_DIV  = `MSCC_SYM_DIV
) (
    input  wire logic                      clk,       // master clock
    input  wire logic                      nrst,      // async reset
    input  wire logic                      ce,        // clock enable
    input  wire logic                      restart,   // realign to phase 0
    input  wire logic                      follow,    // slave to extStrobe
    input  wire logic                      extStrobe, // strobe to follow
    input  wire logic                      slip,      // retard one cycle
    input  wire logic                      advance,   // advance one cycle
    output mscc_pkg::mscc_strobes_type     strobes    // derived strobes
);
    logic [15:0] convCnt;
    logic [15:0] next_convCnt;
    logic [7:0]  bitCnt;
    logic [7:0]  next_bitCnt;
    logic [7:0]  symCnt;
    logic [7:0]  next_symCnt;
    mscc_pkg::mscc_strobes_type next_strobes;
    logic        conv;

    always_comb begin
        conv = 1'b0;
        next_convCnt = convCnt;
        if (restart) begin
            next_convCnt = 16'h0000;
        end else if (follow) begin
            conv = extStrobe;
            next_convCnt = 16'h0000;
        end else if (slip) begin
            next_convCnt = convCnt;
        end else if (convCnt >= 16'(CONV_DIV - 1)) begin
            // an advance at the wrap shortens the next period instead
            conv = 1'b1;
            next_convCnt = advance ? 16'h0001 : 16'h0000;
        end else if (advance && convCnt >= 16'(CONV_DIV - 2)) begin
            conv = 1'b1;
            next_convCnt = 16'h0000;
        end else begin
            next_convCnt = convCnt + (advance ? 16'h0002 : 16'h0001);
        end
        // bit and symbol clocks count conversion strobes only
        next_bitCnt = bitCnt;
        next_symCnt = symCnt;
        next_strobes = '0;
        next_strobes.convert = conv;
        if (restart) begin
            next_bitCnt = 8'h00;
            next_symCnt = 8'h00;
        end else if (conv) begin
            next_bitCnt = (bitCnt >= 8'(BIT_DIV - 1)) ? 8'h00 : bitCnt + 8'h01;
            next_symCnt = (symCnt >= 8'(SYM_DIV - 1)) ? 8'h00 : symCnt + 8'h01;
            next_strobes.bitClk    = (bitCnt >= 8'(BIT_DIV - 1));
            next_strobes.symbolClk = (symCnt >= 8'(SYM_DIV - 1));
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            convCnt <= 16'h0000;
            bitCnt  <= 8'h00;
            symCnt  <= 8'h00;
            strobes <= '0;
        end else if (ce) begin
            convCnt <= next_convCnt;
            bitCnt  <= next_bitCnt;
            symCnt  <= next_symCnt;
            strobes <= next_strobes;
        end
    end
endmodule // mscc_strobe_gen

// *** hw/mscc_clock_mode_ctrl.sv ***
// Functional notes
// - mode field: 000 async fallback, 111 async terminal_sync_input, 100/101/110 V.32.
// - V.32 terminal_sync_input and internal: interpolator loads on transmit strobe.
// - same modes: interpolator output on receive strobe; else unused.
// - receive phase adjust applies in every mode.
// - transmit phase adjust only in async fallback and V.32 internal.
// - loopback: receive phase changes shift transmit clocks equally.
// - receive bit and symbol clocks derive from receive strobe.
// - transmit bit and symbol clocks derive from transmit strobe.
// - async terminal_sync_input: transmit locked to terminal sync, receive free.
// - V.32 terminal_sync_input: lock receive to transmit first, then transmit to sync.
// - entering V.32 from non-V.32 mode performs a soft reset.
// - loopback: all clocks except receive strobe locked to receive strobe.
`timescale 1ns/1ps
`include "mscc_map.svh"
module mscc_clock_mode_ctrl #(
    parameter int CONV_DIV = `MSCC_CONV_DIV,
    parameter int PHASE_W  = `MSCC_PHASE_W
) (
    input  wire logic                   clk,             // 13.824 MHz master
    input  wire logic                   nrst,            // async reset
    input  wire logic                   ce,              // clock enable
    input  wire logic [2:0]             operatingMode,   // mode field
    input  wire logic [PHASE_W-1:0]     rxPhaseAdjust,   // signed rx phase
    input  wire logic [PHASE_W-1:0]     txPhaseAdjust,   // signed tx phase
    input  wire logic                   terminalSyncIn,  // pin, async
    output mscc_pkg::mscc_strobes_type  rxClocks,        // rx strobes
    output mscc_pkg::mscc_strobes_type  txClocks,        // tx strobes
    output logic                        adcUpdate,       // adc pacing
    output logic                        dacUpdate,       // dac pacing
    output logic                        interpLoad,      // interp input
    output logic                        interpOut,       // interp output
    output logic                        interpEnable,    // interp in use
    output logic                        loopActive,      // tracking loop on
    output logic                        softReset        // soft reset pulse
);
    // CONV_DIV assumes the 13.824 MHz master clock
    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    logic syncMeta;
    logic syncIn;
    logic syncPrev;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncMeta <= 1'b0;
            syncIn   <= 1'b0;
            syncPrev <= 1'b0;
        end else if (ce) begin
            syncMeta <= terminalSyncIn;
            syncIn   <= syncMeta;
            syncPrev <= syncIn;
        end
    end
    logic syncEdge;
    assign syncEdge = syncIn & ~syncPrev;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic isAsyncTs;
    logic isV32Ts;
    logic isV32Int;
    logic isLoop;
    logic isV32;
    always_comb begin
        isAsyncTs = (operatingMode == `MSCC_MODE_ASYNC_TERMINAL_SYNC_INPUT);
        isV32Ts   = (operatingMode == `MSCC_MODE_V32_TERMINAL_SYNC_INPUT);
        isV32Int  = (operatingMode == `MSCC_MODE_V32_INT);
        isLoop    = (operatingMode == `MSCC_MODE_V32_LOOP);
        isV32     = isV32Ts | isV32Int | isLoop;
    end

    // ------------------------------------------------------------
    // mode tracking, soft reset and lock sequence
    // ------------------------------------------------------------
    mscc_pkg::mscc_lock_type lockState;
    mscc_pkg::mscc_lock_type next_lockState;
    logic [2:0] lastMode;
    logic [2:0] next_lastMode;
    logic [3:0] rstCnt;
    logic [3:0] next_rstCnt;
    logic       next_softReset;
    logic       rxConv;
    logic       txConv;
    logic       modeChange;

    assign modeChange = (operatingMode != lastMode);

    always_comb begin
        next_lastMode  = operatingMode;
        next_lockState = lockState;
        next_rstCnt    = (rstCnt != 4'h0) ? rstCnt - 4'h1 : 4'h0;
        next_softReset = (rstCnt > 4'h1);
        if (modeChange) begin
            if (isV32 && !(lastMode == `MSCC_MODE_V32_TERMINAL_SYNC_INPUT ||
                           lastMode == `MSCC_MODE_V32_INT ||
                           lastMode == `MSCC_MODE_V32_LOOP)) begin
                next_rstCnt    = `MSCC_RESET_CYCLES;
                next_softReset = 1'b1;
            end
            next_lockState = (isV32Ts | isV32Int)
                           ? mscc_pkg::MSCC_LK_RXTX
                           : mscc_pkg::MSCC_LK_IDLE;
        end else begin
            case (lockState)
                mscc_pkg::MSCC_LK_IDLE: begin
                    next_lockState = mscc_pkg::MSCC_LK_IDLE;
                end
                mscc_pkg::MSCC_LK_RXTX: begin
                    // rx locked once it realigns on a tx strobe
                    if (txConv && isV32Ts) begin
                        next_lockState = mscc_pkg::MSCC_LK_TRACK;
                    end else if (txConv) begin
                        next_lockState = mscc_pkg::MSCC_LK_IDLE;
                    end
                end
                mscc_pkg::MSCC_LK_TRACK: begin
                    next_lockState = mscc_pkg::MSCC_LK_TRACK;
                end
                default: begin
                    next_lockState = mscc_pkg::MSCC_LK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lastMode  <= `MSCC_MODE_ASYNC_FB;
            lockState <= mscc_pkg::MSCC_LK_IDLE;
            rstCnt    <= 4'h0;
            softReset <= 1'b0;
        end else if (ce) begin
            lastMode  <= next_lastMode;
            lockState <= next_lockState;
            rstCnt    <= next_rstCnt;
            softReset <= next_softReset;
        end
    end

    // ------------------------------------------------------------
    // phase adjust: pending signed offsets, one cycle per step
    // ------------------------------------------------------------
    logic [PHASE_W-1:0] rxSeen;
    logic [PHASE_W-1:0] txSeen;
    logic [PHASE_W:0]   rxPend;
    logic [PHASE_W:0]   txPend;
    logic [PHASE_W-1:0] next_rxSeen;
    logic [PHASE_W-1:0] next_txSeen;
    logic [PHASE_W:0]   next_rxPend;
    logic [PHASE_W:0]   next_txPend;
    logic rxAdv;
    logic rxSlip;
    logic txAdv;
    logic txSlip;
    logic txAdjOk;

    assign txAdjOk = (operatingMode == `MSCC_MODE_ASYNC_FB) | isV32Int;

    always_comb begin
        next_rxSeen = rxPhaseAdjust;
        next_txSeen = txPhaseAdjust;
        next_rxPend = rxPend;
        next_txPend = txPend;
        rxAdv  = ~rxPend[PHASE_W] & (rxPend != '0);
        rxSlip = rxPend[PHASE_W];
        txAdv  = txAdjOk & ~txPend[PHASE_W] & (txPend != '0);
        txSlip = txAdjOk & txPend[PHASE_W];
        if (rxAdv) next_rxPend = rxPend - 1'b1;
        if (rxSlip) next_rxPend = rxPend + 1'b1;
        if (txAdv) next_txPend = txPend - 1'b1;
        if (txSlip) next_txPend = txPend + 1'b1;
        // new write adds the difference to the pending offset
        if (rxPhaseAdjust != rxSeen) begin
            next_rxPend = next_rxPend + {rxPhaseAdjust[PHASE_W-1],
                rxPhaseAdjust} - {rxSeen[PHASE_W-1], rxSeen};
        end
        if (!txAdjOk) begin
            next_txPend = '0;
        end else if (txPhaseAdjust != txSeen) begin
            next_txPend = next_txPend + {txPhaseAdjust[PHASE_W-1],
                txPhaseAdjust} - {txSeen[PHASE_W-1], txSeen};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxSeen <= '0;
            txSeen <= '0;
            rxPend <= '0;
            txPend <= '0;
        end else if (ce) begin
            rxSeen <= next_rxSeen;
            txSeen <= next_txSeen;
            rxPend <= next_rxPend;
            txPend <= next_txPend;
        end
    end

    // ------------------------------------------------------------
    // strobe generators
    // ------------------------------------------------------------
    mscc_pkg::mscc_strobes_type rxGen;
    mscc_pkg::mscc_strobes_type txGen;
    logic txFollowRx;
    logic txFollowSync;
    logic rxFollowTx;

    // loopback tx follows rx strobe, so rx adjust moves tx
    assign txFollowRx   = isLoop;
    // only terminal_sync_input modes track the terminal sync
    assign txFollowSync = isAsyncTs |
        (isV32Ts && lockState == mscc_pkg::MSCC_LK_TRACK);
    // initial alignment of rx on tx in the V.32 terminal_sync_input and internal modes
    assign rxFollowTx   = (lockState == mscc_pkg::MSCC_LK_RXTX);

    mscc_strobe_gen #(
        .CONV_DIV (CONV_DIV)
    ) u_rx (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .restart   (softReset),
        .follow    (rxFollowTx),
        .extStrobe (txGen.convert),
        .slip      (rxSlip),
        .advance   (rxAdv),
        .strobes   (rxGen)
    );

    mscc_strobe_gen #(
        .CONV_DIV (CONV_DIV)
    ) u_tx (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .restart   (softReset),
        .follow    (txFollowRx | txFollowSync),
        .extStrobe (txFollowRx ? rxGen.convert : syncEdge),
        .slip      (txSlip),
        .advance   (txAdv),
        .strobes   (txGen)
    );

    assign rxConv = rxGen.convert;
    assign txConv = txGen.convert;

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic interpOn;
    assign interpOn = isV32Ts | isV32Int;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxClocks     <= '0;
            txClocks     <= '0;
            adcUpdate    <= 1'b0;
            dacUpdate    <= 1'b0;
            interpLoad   <= 1'b0;
            interpOut    <= 1'b0;
            interpEnable <= 1'b0;
            loopActive   <= 1'b0;
        end else if (ce) begin
            rxClocks     <= rxGen;
            txClocks     <= txGen;
            adcUpdate    <= isV32 ? txConv : rxConv;
            dacUpdate    <= txConv;
            interpLoad   <= interpOn & txConv;
            interpOut    <= interpOn & rxConv;
            interpEnable <= interpOn;
            loopActive   <= txFollowSync;
        end
    end
endmodule // mscc_clock_mode_ctrl

// *** verif/mscc_sync_source.sv ***
`timescale 1ns/1ps
// ----
// terminal sync source
// ----
module mscc_sync_source (
    input  wire logic       clk,     // master clock
    input  wire logic       nrst,    // async reset
    input  wire logic       enable,  // pulses only when set
    input  wire logic [7:0] period,  // cycles between rising edges
    output logic            syncOut  // sync pin, low when idle
);
    logic [7:0] count;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= 8'h00;
        end else if (!enable || count >= period - 8'h01) begin
            count <= 8'h00;
        end else begin
            count <= count + 8'h01;
        end
    end
    assign syncOut = enable && (count < 8'h02);
endmodule // mscc_sync_source

// *** verif/mscc_checker.sv ***
`timescale 1ns/1ps
module mscc_checker #(
    parameter int CONV_DIV = 16,
    parameter int PHASE_W  = 8
) (
    input wire logic                       clk,           // master clock
    input wire logic                       nrst,          // async reset
    input wire logic                       ce,            // clock enable
    input wire logic [2:0]                 operatingMode, // mode field
    input wire mscc_pkg::mscc_strobes_type rxClocks,      // rx strobes
    input wire mscc_pkg::mscc_strobes_type txClocks,      // tx strobes
    input wire logic                       adcUpdate,     // adc pacing
    input wire logic                       dacUpdate,     // dac pacing
    input wire logic                       interpLoad,    // interp input
    input wire logic                       interpOut,     // interp output
    input wire logic                       interpEnable,  // interp in use
    input wire logic                       loopActive,    // loop on
    input wire logic                       softReset      // soft reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst || !ce);
    logic v32;
    assign v32 = operatingMode[2] && (operatingMode != 3'h7);
    property p_dac; $stable(operatingMode) |-> dacUpdate == txClocks.convert;
    endproperty
    a_dac: assert property (p_dac) else $error("dac pacing wrong");
    property p_adc_as;
        ($stable(operatingMode) && !v32) |-> adcUpdate == rxClocks.convert;
    endproperty
    a_adc_as: assert property (p_adc_as) else $error("adc pace async");
    property p_adc_v;
        ($stable(operatingMode) && v32) |-> adcUpdate == txClocks.convert;
    endproperty
    a_adc_v: assert property (p_adc_v) else $error("adc pace v32");
    property p_load; interpLoad |-> txClocks.convert && interpEnable;
    endproperty
    a_load: assert property (p_load) else $error("interp load wrong");
    property p_out; interpOut |-> rxClocks.convert && interpEnable;
    endproperty
    a_out: assert property (p_out) else $error("interp out wrong");
    property p_en; $stable(operatingMode) |->
        interpEnable == (operatingMode == 3'h4 || operatingMode == 3'h5);
    endproperty
    a_en: assert property (p_en) else $error("interp enable wrong");
    property p_rxdiv;
        (rxClocks.bitClk || rxClocks.symbolClk) |-> rxClocks.convert;
    endproperty
    a_rxdiv: assert property (p_rxdiv) else $error("rx clock unsynced");
    property p_txdiv;
        (txClocks.bitClk || txClocks.symbolClk) |-> txClocks.convert;
    endproperty
    a_txdiv: assert property (p_txdiv) else $error("tx clock unsynced");
    property p_free; ($stable(operatingMode) && (operatingMode == 3'h0 ||
        operatingMode == 3'h5 || operatingMode == 3'h6)) |-> !loopActive;
    endproperty
    a_free: assert property (p_free) else $error("loop active");
    property p_srst; $rose(softReset) |-> softReset [*7]; endproperty
    a_srst: assert property (p_srst) else $error("soft reset short");
    property p_entry; (v32 && !$past(v32)) |-> ##[1:2] softReset;
    endproperty
    a_entry: assert property (p_entry) else $error("no soft reset");
endmodule // mscc_checker
bind mscc_clock_mode_ctrl mscc_checker #(.CONV_DIV(CONV_DIV),
    .PHASE_W(PHASE_W)) chk (.clk(clk), .nrst(nrst), .ce(ce),
    .operatingMode(operatingMode), .rxClocks(rxClocks),
    .txClocks(txClocks), .adcUpdate(adcUpdate), .dacUpdate(dacUpdate),
    .interpLoad(interpLoad), .interpOut(interpOut),
    .interpEnable(interpEnable), .loopActive(loopActive),
    .softReset(softReset));

// *** verif/modem_sample_clock_mode_control_bench.sv ***
`timescale 1ns/1ps
module modem_sample_clock_mode_control_bench;
    localparam int CDIV = 16;
    logic                       clk = 1'b0;
    logic                       nrst = 1'b0;
    logic                       syncEn = 1'b0;
    logic                       ce = 1'b1;
    logic                       terminalSyncIn;
    logic [2:0]                 operatingMode = 3'h0;
    logic [7:0]                 rxPhaseAdjust = 8'h00;
    logic [7:0]                 txPhaseAdjust = 8'h00;
    mscc_pkg::mscc_strobes_type rxClocks, txClocks;
    logic                       adcUpdate, dacUpdate, interpLoad;
    logic                       interpOut, interpEnable, loopActive;
    logic                       softReset;
    int                         n_mismatch = 0;
    int                         cmp_count = 0;
    always #10 clk = ~clk;
    mscc_sync_source src (.clk(clk), .nrst(nrst), .enable(syncEn),
        .period(8'h14), .syncOut(terminalSyncIn));
    mscc_clock_mode_ctrl #(.CONV_DIV(CDIV), .PHASE_W(8)) dut (.clk(clk),
        .nrst(nrst), .ce(ce), .operatingMode(operatingMode),
        .rxPhaseAdjust(rxPhaseAdjust), .txPhaseAdjust(txPhaseAdjust),
        .terminalSyncIn(terminalSyncIn), .rxClocks(rxClocks),
        .txClocks(txClocks), .adcUpdate(adcUpdate), .dacUpdate(dacUpdate),
        .interpLoad(interpLoad), .interpOut(interpOut),
        .interpEnable(interpEnable), .loopActive(loopActive),
        .softReset(softReset));
    // ----
    // helpers
    // ----
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic logic sig(input int c);
        case (c)
            0: return rxClocks.convert;
            1: return txClocks.convert;
            2: return rxClocks.bitClk;
            3: return rxClocks.symbolClk;
            4: return txClocks.bitClk;
            default: return txClocks.symbolClk;
        endcase
    endfunction
    task automatic give_up(input int k);
        if (k >= 400) begin
            n_mismatch++;
            final_report();
        end
    endtask
    task automatic wait_on(input int c);
        int k;
        for (k = 0; k < 400 && sig(c) !== 1'b1; k++) @(negedge clk);
        give_up(k);
    endtask
    task automatic gap(input int c, output int n);
        wait_on(c);
        @(negedge clk);
        for (n = 1; n < 400 && sig(c) !== 1'b1; n++) @(negedge clk);
        give_up(n);
    endtask
    task automatic offset(output int n);
        wait_on(0);
        for (n = 0; n < 400 && sig(1) !== 1'b1; n++) @(negedge clk);
        give_up(n);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_rates;
        int n;
        int exp [6] = '{CDIV, CDIV, 3 * CDIV, 4 * CDIV, 3 * CDIV, 4 * CDIV};
        for (int c = 0; c < 6; c++) begin
            gap(c, n);
            check(n, exp[c]);
        end
    endtask
    task automatic t_hold;
        int n;
        wait_on(0);
        ce = 1'b0;
        tick(30);
        check(rxClocks.convert, 1'b1);
        ce = 1'b1;
        gap(0, n);
        check(n, CDIV);
    endtask
    task automatic t_phase;
        int a, b;
        offset(a);
        txPhaseAdjust = 8'h03;
        tick(80);
        offset(b);
        check(b, (a + CDIV - 3) % CDIV);
        rxPhaseAdjust = 8'h02;
        tick(80);
        offset(a);
        check(a, (b + 2) % CDIV);
    endtask
    task automatic t_soft;
        int n;
        operatingMode = 3'h5;
        for (n = 0; n < 3 && softReset !== 1'b1; n++) @(negedge clk);
        check(softReset, 1'b1);
        for (n = 0; n < 60 && softReset === 1'b1; n++) @(negedge clk);
        check(n >= 6, 1'b1);
        tick(20);
        operatingMode = 3'h4;
        for (n = 0; n < 12 && softReset !== 1'b1; n++) @(negedge clk);
        check(n, 12);
    endtask
    task automatic t_terminal_sync_input;
        int n;
        syncEn = 1'b1;
        operatingMode = 3'h7;
        tick(80);
        gap(1, n);
        check(n, 20);
        gap(0, n);
        check(n, CDIV);
        check(loopActive, 1'b1);
    endtask
    task automatic t_modes;
        logic [2:0] md [5] = '{3'h0, 3'h7, 3'h4, 3'h5, 3'h6};
        logic       ie [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic       la [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 5; i++) begin
            operatingMode = md[i];
            tick(100);
            check(interpEnable, ie[i]);
            check(loopActive, la[i]);
        end
    endtask
    task automatic t_loop;
        int n;
        tick(80);
        offset(n);
        check(n, 1);
        rxPhaseAdjust = 8'h07;
        tick(80);
        offset(n);
        check(n, 1);
        gap(4, n);
        check(n, 3 * CDIV);
    endtask
    initial begin
        tick(2);
        check({rxClocks, txClocks, adcUpdate, dacUpdate, interpLoad,
            interpOut, interpEnable, loopActive,
            softReset}, 32'h0);
        tick(1);
        nrst = 1'b1;
        tick(10);
        t_rates();
        t_hold();
        t_phase();
        t_soft();
        t_terminal_sync_input();
        t_modes();
        t_loop();
        final_report();
    end
endmodule // modem_sample_clock_mode_control_bench
